// [core/gate_driver_spi_mode_control.v]
// Serial slave port, sleep and mode control, fault recovery
//
// Contract
// - Enable low: sleep, everything disabled
// - Wait sleep-entry delay after enable falls
// - Enable high wakes device; controller waits
// - Sleep or undervoltage: all gates held off
// - Operate only when enabled and supply good; gates stay enabled through the sleep-entry delay after enable falls
// - Latched fault forces partial shutdown
// - Fault-clear bit or enable pulse recovers
// - Reset pulse low phase within window
// - Reset pulse clears only latched faults
// - Slave; 16-bit frame, command then data
// - Select high: ignore inputs, output tristate
// - Sample on falling, change on rising
// - Most significant bit first both ways
// - Not 16 clocks: frame error, discard
// - B15 read flag, address, data fields
// - Write returns old register contents
// - Read returns current register contents
// - Upper output byte is don't-care
`timescale 1ns/10ps
`include "gate_spi_map.vh"
module gate_driver_spi_mode_control #(
   parameter SLEEP_CYC = `SLEEP_DELAY_CYC,
   parameter WAKE_CYC = `WAKE_DELAY_CYC,
   parameter RST_WIN_CYC = `RESET_WIN_CYC
) (
   input wire ref_clk,
   input wire reset,
   input wire enable_pin,
   input wire supply_ok,
   input wire [7:0] fault_events,
   input wire serial_clk,
   input wire serial_select_n,
   input wire serial_data_in,
   output reg serial_data_out,
   output reg serial_data_oe,
   output wire gates_enabled,
   output wire charge_pump_en,
   output wire digital_supply_regulator_en,
   output wire partial_shutdown,
   output reg sleep_state,
   output reg ready,
   output reg frame_error,
   output reg fault_out
);
   localparam ST_SLEEP = 4'b0001;
   localparam ST_WAKE = 4'b0010;
   localparam ST_RUN = 4'b0100;
   localparam ST_LEAVE = 4'b1000;

   wire en_s;
   wire sclk_s;
   wire cs_n_s;
   wire sdi_s;
   wire ok_s;
   sync_edge u_en (.ref_clk(ref_clk), .reset(reset),
      .async_in(enable_pin), .sync_out(en_s));
   sync_edge u_clk (.ref_clk(ref_clk), .reset(reset),
      .async_in(serial_clk), .sync_out(sclk_s));
   sync_edge u_cs (.ref_clk(ref_clk), .reset(reset),
      .async_in(~serial_select_n), .sync_out(cs_n_s));
   sync_edge u_sdi (.ref_clk(ref_clk), .reset(reset),
      .async_in(serial_data_in), .sync_out(sdi_s));
   sync_edge u_ok (.ref_clk(ref_clk), .reset(reset),
      .async_in(supply_ok), .sync_out(ok_s));

   // cs_n_s is the synchronised select, active high here
   reg sclk_q;
   reg cs_q;
   always @(posedge ref_clk) begin
      if (reset) begin
         sclk_q <= 1'b0;
         cs_q <= 1'b0;
      end else begin
         sclk_q <= sclk_s;
         cs_q <= cs_n_s;
      end
   end
   wire sclk_fall = sclk_q & ~sclk_s;
   wire sclk_rise = ~sclk_q & sclk_s;
   wire cs_start = cs_n_s & ~cs_q;
   wire cs_end = ~cs_n_s & cs_q;

   reg [3:0] state_q;
   reg [31:0] timer_q;
   reg [31:0] low_cnt_q;
   reg fault_latched_q;

   // Registers; status words are 0 to 3, control from 4 upward
   reg [7:0] regs [0:`REG_COUNT-1];
   reg [7:0] ctrl_mem [4:`REG_COUNT-1];

   always @(posedge ref_clk) begin
      if (reset) begin
         state_q <= ST_SLEEP;
         timer_q <= 32'h0000_0000;
         low_cnt_q <= 32'h0000_0000;
         sleep_state <= 1'b1;
         ready <= 1'b0;
      end else begin
         case (state_q)
            ST_SLEEP: begin
               sleep_state <= 1'b1;
               ready <= 1'b0;
               if (en_s && ok_s) begin
                  state_q <= ST_WAKE;
                  timer_q <= 32'h0000_0000;
               end
            end
            ST_WAKE: begin
               sleep_state <= 1'b0;
               if (!en_s) begin
                  state_q <= ST_SLEEP;
               end else if (timer_q >= WAKE_CYC - 1) begin
                  state_q <= ST_RUN;
                  ready <= 1'b1;
               end else begin
                  timer_q <= timer_q + 32'h0000_0001;
               end
            end
            ST_RUN: begin
               if (!en_s) begin
                  state_q <= ST_LEAVE;
                  timer_q <= 32'h0000_0000;
               end else if (!ok_s) begin
                  state_q <= ST_SLEEP;
               end
            end
            ST_LEAVE: begin
               if (en_s) begin
                  state_q <= ST_RUN;
               end else if (timer_q >= SLEEP_CYC - 1) begin
                  state_q <= ST_SLEEP;
                  ready <= 1'b0;
                  sleep_state <= 1'b1;
               end else begin
                  timer_q <= timer_q + 32'h0000_0001;
               end
            end
            default: state_q <= ST_SLEEP;
         endcase
         if (state_q == ST_LEAVE && !en_s)
            low_cnt_q <= low_cnt_q + 32'h0000_0001;
         else if (en_s)
            low_cnt_q <= 32'h0000_0000;
      end
   end

   wire running = (state_q == ST_RUN) | (state_q == ST_LEAVE);
   // Short low phase back to high is the enable reset pulse
   wire en_pulse = (state_q == ST_LEAVE) && en_s &&
      (low_cnt_q <= RST_WIN_CYC);

   // Serial engine
   reg [15:0] shift_in_q;
   reg [15:0] shift_out_q;
   reg [4:0] bit_cnt_q;
   reg clear_req;
   integer i;
   integer k;

   wire [`ADDR_W-1:0] addr = shift_in_q[`ADDR_HI:`ADDR_LO];
   wire is_read = shift_in_q[`RW_BIT];

   always @(posedge ref_clk) begin
      if (reset) begin
         shift_in_q <= 16'h0000;
         shift_out_q <= 16'h0000;
         bit_cnt_q <= 5'h00;
         serial_data_out <= 1'b0;
         serial_data_oe <= 1'b0;
         frame_error <= 1'b0;
         clear_req <= 1'b0;
         for (i = 4; i < `REG_COUNT; i = i + 1)
            ctrl_mem[i] <= 8'h00;
      end else begin
         clear_req <= 1'b0;
         if (!ready) begin
            serial_data_oe <= 1'b0;
            bit_cnt_q <= 5'h00;
         end else if (!cs_n_s) begin
            serial_data_oe <= 1'b0;
            if (cs_end) begin
               if (bit_cnt_q == `FRAME_BITS) begin
                  if (!is_read && addr >= 7'h04 &&
                        addr < `REG_COUNT) begin
                     if (addr == `CTRL1_ADDR &&
                           shift_in_q[`FAULT_CLEAR_POS]) begin
                        clear_req <= 1'b1;
                        ctrl_mem[addr[4:0]] <=
                           shift_in_q[7:0] & 8'h7F;
                     end else begin
                        ctrl_mem[addr[4:0]] <= shift_in_q[7:0];
                     end
                  end
               end else begin
                  frame_error <= 1'b1;
               end
            end
         end else begin
            serial_data_oe <= 1'b1;
            if (cs_start) begin
               bit_cnt_q <= 5'h00;
               frame_error <= 1'b0;
               shift_out_q <= 16'h0000;
               serial_data_out <= 1'b0;
            end else if (sclk_fall) begin
               shift_in_q <= {shift_in_q[14:0], sdi_s};
               if (bit_cnt_q != 5'h1F)
                  bit_cnt_q <= bit_cnt_q + 5'h01;
               if (bit_cnt_q == 5'h07) begin
                  // Old contents load before any store
                  // Register byte sits on top so rises 9 to 16 send it
                  shift_out_q <= {
                     ((({shift_in_q[5:0], sdi_s} < `REG_COUNT)) ?
                     regs[{shift_in_q[3:0], sdi_s}] : 8'h00), 8'h00};
               end
            end else if (sclk_rise) begin
               serial_data_out <= shift_out_q[15];
               shift_out_q <= {shift_out_q[14:0], 1'b0};
            end
         end
      end
   end

   // Sticky fault latch, set beats clear
   always @(posedge ref_clk) begin
      if (reset) begin
         fault_latched_q <= 1'b0;
         fault_out <= 1'b0;
      end else begin
         if (|fault_events && running)
            fault_latched_q <= 1'b1;
         else if (clear_req || en_pulse)
            fault_latched_q <= 1'b0;
         else if (!running)
            fault_latched_q <= 1'b0;
         fault_out <= fault_latched_q;
      end
   end

   always @* begin
      for (k = 0; k < `REG_COUNT; k = k + 1)
         regs[k] = (k >= 4) ? ctrl_mem[k] : 8'h00;
      regs[0] = {fault_latched_q, fault_events[6:0] &
         {7{fault_latched_q}}};
   end

   assign partial_shutdown = fault_latched_q;
   assign gates_enabled = running & ok_s & ~fault_latched_q;
   assign charge_pump_en = running;
   assign digital_supply_regulator_en = ~sleep_state;
endmodule

// [core/gate_spi_map.vh]
// Constants for the gate driver serial port and mode control
`ifndef GATE_SPI_MAP_VH
`define GATE_SPI_MAP_VH
`define CLK_FREQ_MHZ 20
`define FRAME_BITS 16
`define RW_BIT 15
`define ADDR_HI 14
`define ADDR_LO 8
`define ADDR_W 7
`define REG_COUNT 18
`define FAULT_STATUS_ADDR 7'h00
`define DIAG_A_ADDR 7'h01
`define DIAG_C_ADDR 7'h03
`define CTRL1_ADDR 7'h04
`define FAULT_CLEAR_POS 7
`define SLEEP_DELAY_US 100
`define SLEEP_DELAY_CYC ((`SLEEP_DELAY_US * `CLK_FREQ_MHZ) / 1)
`define WAKE_DELAY_US 1000
`define WAKE_DELAY_CYC ((`WAKE_DELAY_US * `CLK_FREQ_MHZ) / 1)
`define RESET_WIN_US 20
`define RESET_WIN_CYC ((`RESET_WIN_US * `CLK_FREQ_MHZ) / 1)
`endif

// [core/sync_edge.v]
// Two-flop synchroniser for one outside level
`timescale 1ns/10ps
module sync_edge (
   input wire ref_clk,
   input wire reset,
   input wire async_in,
   output wire sync_out
);
   reg meta_q;
   reg stable_q;
   always @(posedge ref_clk) begin
      if (reset) begin
         meta_q <= 1'b0;
         stable_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         stable_q <= meta_q;
      end
   end
   assign sync_out = stable_q;
endmodule

// [tb/spi_master_model.sv]
// Serial master model that frames words into the gate driver port
`timescale 1ns/10ps
module spi_master_model (
   output logic sclk,
   output logic sel_n,
   output logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   initial begin
      sclk = 1'b0;
      sel_n = 1'b1;
      sdi = 1'b0;
   end
   // Undriven output bits are kept as unknown so a stray drive shows up
   task automatic xfer(input int n, input logic [16:0] w,
      output logic [15:0] r);
      sel_n <= 1'b0;
      #200;
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= w[i];
         sclk <= 1'b1;
         #200;
         sclk <= 1'b0;
         r = {r[14:0], sdo_oe ? sdo : 1'bx};
         #200;
      end
      sel_n <= 1'b1;
      sdi <= ~sdi;
      #400;
   endtask
endmodule

// [tb/gate_driver_spi_mode_control_properties.sv]
// Assertions on the serial port, sleep and fault control
`timescale 1ns/10ps
module gate_driver_spi_mode_control_properties #(
   parameter SLEEP_CYC = 20,
   parameter WAKE_CYC = 40,
   parameter RST_WIN_CYC = 10
) (
   input wire ref_clk, reset, enable_pin, supply_ok, serial_select_n,
   input wire [7:0] fault_events,
   input wire serial_data_oe, gates_enabled, charge_pump_en,
   input wire digital_supply_regulator_en, partial_shutdown,
   input wire sleep_state, ready, fault_out
);
   logic [15:0] lo_q, hi_q;
   // Raw pin counters lead the synchronised view, so bounds stay safe
   always @(posedge ref_clk) begin
      if (reset || enable_pin) lo_q <= 16'h0000;
      else if (lo_q != 16'hFFFF) lo_q <= lo_q + 16'h0001;
      if (reset || !(enable_pin && supply_ok)) hi_q <= 16'h0000;
      else if (hi_q != 16'hFFFF) hi_q <= hi_q + 16'h0001;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence sel_idle; serial_select_n [*4]; endsequence
   sequence fault_hit; (|fault_events) && ready; endsequence
   AST_OE_IDLE: assert property (sel_idle |-> !serial_data_oe)
      else $error("output driven while deselected");
   AST_SLEEP_OFF: assert property (sleep_state |-> !gates_enabled &&
      !charge_pump_en && !digital_supply_regulator_en)
      else $error("block active in sleep");
   AST_SLEEP_OE: assert property (sleep_state [*2] |-> !serial_data_oe)
      else $error("serial output driven in sleep");
   AST_UV_OFF: assert property (!supply_ok [*4] |-> !gates_enabled)
      else $error("gates on under lockout");
   AST_SLEEP_EARLY: assert property ($rose(sleep_state) && !enable_pin |->
      lo_q >= SLEEP_CYC) else $error("sleep entered too early");
   AST_SLEEP_LATE: assert property (lo_q == SLEEP_CYC + 8 |->
      sleep_state) else $error("sleep not entered");
   AST_READY_AWAKE: assert property (ready |-> !sleep_state)
      else $error("ready while asleep");
   AST_WAKE: assert property ($rose(ready) |-> hi_q >= WAKE_CYC)
      else $error("ready before wake delay");
   AST_FAULT: assert property (fault_hit |-> ##[1:4]
      (fault_out && partial_shutdown)) else $error("fault not latched");
   AST_SHUT_GATES: assert property (partial_shutdown |-> !gates_enabled)
      else $error("gates on in shutdown");
endmodule
bind gate_driver_spi_mode_control gate_driver_spi_mode_control_properties
   #(.SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC), .RST_WIN_CYC(RST_WIN_CYC))
   props_i (.*);

// [tb/gate_driver_spi_mode_control_bench.sv]
// Self-checking bench for the gate driver serial and mode control
`timescale 1ns/10ps
module gate_driver_spi_mode_control_bench;
   logic ref_clk = 1'b0, reset = 1'b1, enable_pin = 1'b0, supply_ok = 1'b0;
   logic [7:0] fault_events = 8'h00;
   logic [15:0] r;
   wire sck, sel_n, sdi, sdo, oe, gates, cp_en, dreg_en, shut;
   wire sleep_state, ready, frame_error, fault_out;
   int n_mismatch = 0, n_tests = 0, cycles = 0;
   always #25 ref_clk = ~ref_clk;
   gate_driver_spi_mode_control #(.SLEEP_CYC(20), .WAKE_CYC(40),
      .RST_WIN_CYC(10)) dut (.ref_clk(ref_clk), .reset(reset),
      .enable_pin(enable_pin), .supply_ok(supply_ok),
      .fault_events(fault_events), .serial_clk(sck),
      .serial_select_n(sel_n), .serial_data_in(sdi), .serial_data_out(sdo),
      .serial_data_oe(oe), .gates_enabled(gates), .charge_pump_en(cp_en),
      .digital_supply_regulator_en(dreg_en), .partial_shutdown(shut),
      .sleep_state(sleep_state), .ready(ready), .frame_error(frame_error),
      .fault_out(fault_out));
   spi_master_model m (.sclk(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo),
      .sdo_oe(oe));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wait_ready;
      for (int i = 0; i < 200 && ready !== 1'b1; i++) tick(1);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      m.xfer(16, {2'b00, a, d}, r);
   endtask
   task automatic rd(input logic [6:0] a);
      m.xfer(16, {2'b01, a, 8'h00}, r);
   endtask
   task automatic t_wake;
      chk(sleep_state, 8'h01);
      enable_pin <= 1'b1;
      supply_ok <= 1'b1;
      tick(20);
      chk(ready, 8'h00);
      wait_ready;
      chk(ready, 8'h01);
      chk(cp_en, 8'h01);
   endtask
   task automatic t_regs;
      // Address 0x05 and the top of the writable range, 0x11, written back to back
      for (int i = 0; i < 2; i++) begin
         wr(i ? 7'h11 : 7'h05, 8'h5A);
         wr(i ? 7'h11 : 7'h05, 8'hA5);
         chk(r[7:0], 8'h5A);
         rd(i ? 7'h11 : 7'h05);
         chk(r[7:0], 8'hA5);
      end
   endtask
   task automatic t_frame;
      m.xfer(15, {2'b00, 7'h05, 8'h33}, r);
      chk(frame_error, 8'h01);
      m.xfer(17, {2'b00, 7'h05, 8'h33}, r);
      chk(frame_error, 8'h01);
      rd(7'h05);
      chk(r[7:0], 8'hA5);
      chk(frame_error, 8'h00);
   endtask
   task automatic t_fault;
      fault_events <= 8'h01;
      tick(2);
      fault_events <= 8'h00;
      tick(4);
      chk(fault_out, 8'h01);
      wr(7'h04, 8'h80);
      tick(4);
      chk(fault_out, 8'h00);
      fault_events <= 8'h01;
      tick(2);
      fault_events <= 8'h00;
      tick(4);
      enable_pin <= 1'b0;
      tick(5);
      enable_pin <= 1'b1;
      tick(8);
      chk(fault_out, 8'h00);
      chk(ready, 8'h01);
      rd(7'h05);
      chk(r[7:0], 8'hA5);
   endtask
   task automatic t_sleep;
      supply_ok <= 1'b0;
      tick(6);
      chk(gates, 8'h00);
      supply_ok <= 1'b1;
      wait_ready;
      chk(ready, 8'h01);
      enable_pin <= 1'b0;
      tick(10);
      chk(sleep_state, 8'h00);
      tick(20);
      chk(sleep_state, 8'h01);
      wr(7'h05, 8'h11);
      chk(r[7:0], 8'hxx);
      enable_pin <= 1'b1;
      wait_ready;
      chk(ready, 8'h01);
      rd(7'h05);
      chk(r[7:0], 8'hA5);
   endtask
   initial begin
      tick(5);
      reset <= 1'b0;
      t_wake;
      t_regs;
      t_frame;
      t_fault;
      t_sleep;
      final_report;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report;
      end
   end
endmodule
